// *** design/port_c_alt_function_mux.sv ***
// Overview of operation
// RULE_01 - Fuse programmed: pin 6 is plain input; reset only power-on, brown-out.
// RULE_02 - Fuse unprogrammed: pin 6 goes to reset logic, not usable as input.
// RULE_03 - Pin 6 as reset: direction, output and input bits read zero.
// RULE_04 - Two-wire enable hands pin 5 to the interface as clock line.
// RULE_05 - Two-wire enable hands pin 4 to the interface as data line.
// RULE_06 - Two-wire inputs filtered; pulses under 50 ns are suppressed.
// RULE_07 - Two-wire lines are open-drain: only pull low, never drive high.
// RULE_08 - Filters sit between pin input path and two-wire logic.
// RULE_09 - Pin n feeds pin-change source 8+n, covering sources 8 to 15.
// RULE_10 - Pins 0 to 5 are ADC channels 0 to 5.
// RULE_11 - ADC pins: input enable overridden by disable bit or pin-change.
// RULE_12 - Pin 6: input override on fuse or pin-change; fuse keeps enabled.
// RULE_13 - Two-wire mode: pull-up from output bit and pull-up disable.
// RULE_14 - Override value replaces register setting while its enable is set.
`include "port_c_mux_defines.svh"

module port_c_alt_function_mux
	import port_c_mux_pkg::*;
#(
	parameter int unsigned WIDTH       = `PORT_WIDTH,
	parameter int unsigned SPIKE_CYCLES = `SPIKE_CYCLES
) (
	input  wire logic             ref_clk,
	input  wire logic             nrst,
	input  wire logic             clkEn,
	input  wire logic             reset_pin_disable_fuse,
	input  wire logic             two_wire_enable,
	input  wire logic             pin_change_group1_enable,
	input  wire logic             global_pullup_disable,
	input  wire logic [WIDTH-1:0] portDirReg,
	input  wire logic [WIDTH-1:0] portOutReg,
	input  wire logic [WIDTH-1:0] pinChangeMask,
	input  wire logic [5:0]       adcDiginDisable,
	input  wire logic             sclDriveLow,
	input  wire logic             sdaDriveLow,
	input  wire logic [WIDTH-1:0] padIn,
	output logic      [WIDTH-1:0] padOut,
	output logic      [WIDTH-1:0] padOutEn,
	output logic      [WIDTH-1:0] padPullup,
	output logic      [WIDTH-1:0] padDiginEn,
	output logic      [WIDTH-1:0] pinInputRead,
	output logic      [WIDTH-1:0] dirRead,
	output logic      [WIDTH-1:0] outRead,
	output logic      [15:8]      pinChangeSrc,
	output logic      [5:0]       adcChannelSel,
	output logic                  extResetLevel,
	output logic                  sclIn,
	output logic                  sdaIn,
	output pin_owner_type         twiOwner
);
	localparam int RP  = `RESET_PIN_IDX;
	localparam int SCL = `SCL_PIN_IDX;
	localparam int SDA = `SDA_PIN_IDX;

	// Reset pin is active unless the fuse reclaims it
	wire logic rstPinMode = !reset_pin_disable_fuse; // RULE_02

	logic [WIDTH-1:0] sync1_q;
	logic [WIDTH-1:0] sync2_q;
	logic [WIDTH-1:0] dirOut_q;
	logic [WIDTH-1:0] valOut_q;
	logic [WIDTH-1:0] pull_q;
	logic [WIDTH-1:0] dien_q;
	logic [WIDTH-1:0] pinRd_q;
	logic [WIDTH-1:0] dirRd_q;
	logic [WIDTH-1:0] outRd_q;
	logic [5:0]       adcSel_q;
	logic             rstLvl_q;
	pin_owner_type    owner_q;

	logic [WIDTH-1:0] pullup_override_en, pullup_override_val, direction_override_en, direction_override_val, outval_override_en, outval_override_val, digin_enable_override_en, digin_enable_override_val;
	logic [WIDTH-1:0] dirD, valD, pullD, dienD, pinRdD, dirRdD, outRdD;

	// Reset mode takes the port driver off the reset pin, so a stray
	// direction bit cannot pull the line low and reset the part
	wire logic [WIDTH-1:0] rstCut  = rstPinMode ? (WIDTH'(1) << RP) : '0;
	wire logic [WIDTH-1:0] dirLive = dirD & ~rstCut;            // RULE_02
	wire logic [WIDTH-1:0] valLive = valD & ~rstCut;            // RULE_02

	// Peripheral feeds decoded ahead of their flops
	wire logic     rstLvlD = rstPinMode ? sync2_q[RP] : 1'b1;  // RULE_02
	pin_owner_type ownerD;
	assign ownerD = two_wire_enable ? OWNER_TWI_type : OWNER_PORT_type;

	// Per-pin override pairs; only the pins with alternate roles vary
	genvar n;
	generate
		for (n = 0; n < WIDTH; n++) begin : g_pin
			wire logic pcEn = pinChangeMask[n] & pin_change_group1_enable;
			if (n == RP) begin : g_rst
				assign pullup_override_en[n]  = reset_pin_disable_fuse;      // RULE_01
				assign pullup_override_val[n]  = 1'b1;
				assign direction_override_en[n]  = reset_pin_disable_fuse;
				assign direction_override_val[n]  = 1'b0;
				assign outval_override_en[n]  = 1'b0;
				assign outval_override_val[n]  = 1'b0;
				assign digin_enable_override_en[n] = reset_pin_disable_fuse | pcEn; // RULE_12
				assign digin_enable_override_val[n] = reset_pin_disable_fuse;        // RULE_12
			end else if (n == SCL || n == SDA) begin : g_twi
				wire logic drvLow = (n == SCL) ? sclDriveLow : sdaDriveLow;
				assign pullup_override_en[n]  = two_wire_enable;               // RULE_13
				assign pullup_override_val[n]  = portOutReg[n] & !global_pullup_disable;
				assign direction_override_en[n]  = two_wire_enable;               // RULE_04 RULE_05
				assign direction_override_val[n]  = drvLow;                        // RULE_07
				assign outval_override_en[n]  = two_wire_enable;               // RULE_07
				assign outval_override_val[n]  = 1'b0;                          // RULE_07
				assign digin_enable_override_en[n] = pcEn | adcDiginDisable[n];     // RULE_11
				assign digin_enable_override_val[n] = pcEn;                          // RULE_11
			end else if (n < `ADC_PIN_COUNT) begin : g_adc
				assign pullup_override_en[n]  = 1'b0;
				assign pullup_override_val[n]  = 1'b0;
				assign direction_override_en[n]  = 1'b0;
				assign direction_override_val[n]  = 1'b0;
				assign outval_override_en[n]  = 1'b0;
				assign outval_override_val[n]  = 1'b0;
				assign digin_enable_override_en[n] = pcEn | adcDiginDisable[n];     // RULE_11
				assign digin_enable_override_val[n] = pcEn;                          // RULE_11
			end else begin : g_plain
				assign pullup_override_en[n]  = 1'b0;
				assign pullup_override_val[n]  = 1'b0;
				assign direction_override_en[n]  = 1'b0;
				assign direction_override_val[n]  = 1'b0;
				assign outval_override_en[n]  = 1'b0;
				assign outval_override_val[n]  = 1'b0;
				assign digin_enable_override_en[n] = pcEn;
				assign digin_enable_override_val[n] = 1'b1;
			end
			// Register settings yield to active overrides
			wire logic regPull = !portDirReg[n] & portOutReg[n]
				& !global_pullup_disable;
			assign dirD[n]  = direction_override_en[n] ? direction_override_val[n] : portDirReg[n];  // RULE_14
			assign valD[n]  = outval_override_en[n] ? outval_override_val[n] : portOutReg[n];  // RULE_14
			assign pullD[n] = pullup_override_en[n] ? pullup_override_val[n] : regPull;        // RULE_14
			assign dienD[n] = digin_enable_override_en[n] ? digin_enable_override_val[n] : 1'b1;         // RULE_14
			// Reset pin hides its register bits from software
			if (n == RP) begin : g_rdrst
				assign pinRdD[n] = rstPinMode ? 1'b0 : sync2_q[n]; // RULE_03
				assign dirRdD[n] = rstPinMode ? 1'b0 : portDirReg[n]; // RULE_03
				assign outRdD[n] = rstPinMode ? 1'b0 : portOutReg[n]; // RULE_03
			end else begin : g_rd
				assign pinRdD[n] = dienD[n] & sync2_q[n];
				assign dirRdD[n] = portDirReg[n];
				assign outRdD[n] = portOutReg[n];
			end
		end
	endgenerate

	// Pad inputs are asynchronous, so synchronise before use
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else if (clkEn) begin
			sync1_q <= padIn;
			sync2_q <= sync1_q;
		end
	end

	// Registered pad controls keep data outputs glitch free
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			dirOut_q <= '0;
			valOut_q <= '0;
			pull_q   <= '0;
			dien_q   <= '1;
		end else if (clkEn) begin
			dirOut_q <= dirLive;
			valOut_q <= valLive;
			pull_q   <= pullD;
			dien_q   <= dienD;
		end
	end

	// Software-visible readback and peripheral feeds
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			pinRd_q  <= '0;
			dirRd_q  <= '0;
			outRd_q  <= '0;
			adcSel_q <= '0;
			rstLvl_q <= 1'b1;
			owner_q  <= OWNER_PORT_type;
		end else if (clkEn) begin
			pinRd_q  <= pinRdD;
			dirRd_q  <= dirRdD;
			outRd_q  <= outRdD;
			adcSel_q <= adcDiginDisable;                         // RULE_10
			rstLvl_q <= rstLvlD;
			owner_q  <= ownerD;
		end
	end

	// Filters see the raw pad; synchroniser lives inside each filter
	spike_filter #(.MIN_CYCLES(SPIKE_CYCLES)) u_scl_filt (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.clkEn   (clkEn),
		.rawIn   (padIn[SCL]),
		.filtOut (sclIn)                                     // RULE_08
	);

	spike_filter #(.MIN_CYCLES(SPIKE_CYCLES)) u_sda_filt (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.clkEn   (clkEn),
		.rawIn   (padIn[SDA]),
		.filtOut (sdaIn)                                     // RULE_08
	);

	// Pin n drives pin-change source 8+n
	assign pinChangeSrc  = pinRd_q;                          // RULE_09
	assign padOutEn      = dirOut_q;
	assign padOut        = valOut_q;
	assign padPullup     = pull_q;
	assign padDiginEn    = dien_q;
	assign pinInputRead  = pinRd_q;
	assign dirRead       = dirRd_q;
	assign outRead       = outRd_q;
	assign adcChannelSel = adcSel_q;
	assign extResetLevel = rstLvl_q;
	assign twiOwner      = owner_q;
endmodule

// *** design/port_c_mux_defines.svh ***
`ifndef PORT_C_MUX_DEFINES_SVH
`define PORT_C_MUX_DEFINES_SVH

// Port geometry
`define PORT_WIDTH          8
`define ADC_PIN_COUNT       6
`define RESET_PIN_IDX       6
`define SCL_PIN_IDX         5
`define SDA_PIN_IDX         4
`define PCINT_BASE          8

// Spike filter timing
`define CLK_PERIOD_PS       25000
`define SPIKE_MIN_NS        50
`define SPIKE_CYCLES \
	((`SPIKE_MIN_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

// Reset values
`define LINE_IDLE_RESET     1'b1

`endif

// *** design/port_c_mux_pkg.sv ***
package port_c_mux_pkg;
	// Owner of the shared two-wire pins
	typedef enum logic [1:0] {
		OWNER_PORT_type = 2'b01,
		OWNER_TWI_type  = 2'b10
	} pin_owner_type;
endpackage

// *** design/spike_filter.sv ***
`include "port_c_mux_defines.svh"

module spike_filter #(
	parameter int unsigned MIN_CYCLES = `SPIKE_CYCLES
) (
	input  wire logic ref_clk,
	input  wire logic nrst,
	input  wire logic clkEn,
	input  wire logic rawIn,
	output logic      filtOut
);
	localparam int unsigned CW = $clog2(MIN_CYCLES + 1);

	logic          sync1_q;
	logic          sync2_q;
	logic          filt_q;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	wire  logic    differs = (sync2_q != filt_q);
	wire  logic    settled = (cnt_q == CW'(MIN_CYCLES - 1));

	// Restart the count whenever the input agrees with the output again
	assign cnt_d = !differs ? '0 : (settled ? cnt_q : cnt_q + CW'(1));

	// Two-stage sync, then the level must hold before it passes
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			sync1_q <= `LINE_IDLE_RESET;
			sync2_q <= `LINE_IDLE_RESET;
			filt_q  <= `LINE_IDLE_RESET;
			cnt_q   <= '0;
		end else if (clkEn) begin
			sync1_q <= rawIn;
			sync2_q <= sync1_q;
			cnt_q   <= cnt_d;
			if (differs && settled)
				filt_q <= sync2_q; // RULE_06
		end
	end

	assign filtOut = filt_q;
endmodule

// *** bench/pad_model.sv ***
module pad_model (
	input  wire logic [7:0] padOut,
	input  wire logic [7:0] padOutEn,
	input  wire logic [7:0] extVal,
	output logic      [7:0] padIn
);
	timeunit 1ns;
	timeprecision 1ps;
	wire logic [7:0] plain = (padOutEn & padOut) | (~padOutEn & extVal);
	// Two-wire lines: wired-AND with a bus pull-up, chip only sinks
	assign padIn = {plain[7:6], extVal[5:4] & ~(padOutEn[5:4] & ~padOut[5:4]),
		plain[3:0]};
endmodule

// *** bench/port_c_mux_props.sv ***
module port_c_mux_props
	import port_c_mux_pkg::*;
#(
	parameter int unsigned SPIKE_CYCLES = 2
) (
	input wire logic          ref_clk,
	input wire logic          nrst,
	input wire logic          reset_pin_disable_fuse,
	input wire logic          two_wire_enable,
	input wire logic          pin_change_group1_enable,
	input wire logic [7:0]    portDirReg,
	input wire logic [7:0]    pinChangeMask,
	input wire logic [5:0]    adcDiginDisable,
	input wire logic          sclDriveLow,
	input wire logic          sdaDriveLow,
	input wire logic [7:0]    padOut,
	input wire logic [7:0]    padOutEn,
	input wire logic [7:0]    padDiginEn,
	input wire logic [7:0]    pinInputRead,
	input wire logic [7:0]    dirRead,
	input wire logic [7:0]    outRead,
	input wire logic [15:8]   pinChangeSrc,
	input wire logic [5:0]    adcChannelSel,
	input wire logic          extResetLevel,
	input wire pin_owner_type twiOwner,
	input wire logic [7:0]    padIn,
	input wire logic          sclIn,
	input wire logic          sdaIn
);
	timeunit 1ns;
	timeprecision 1ps;
	// Outputs follow inputs one edge later
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	a_twi_zero: assert property (
		$past(two_wire_enable) |-> padOut[5:4] == 2'h0) else $error("twi high");
	a_twi_dir: assert property (
		$past(two_wire_enable) |-> padOutEn[5:4] ==
		$past({sclDriveLow, sdaDriveLow})) else $error("twi dir");
	a_port_dir: assert property (
		!$past(two_wire_enable) |-> padOutEn[5:0] == $past(portDirReg[5:0]))
		else $error("port dir");
	a_rst_read: assert property (
		!$past(reset_pin_disable_fuse) |-> !dirRead[6] && !outRead[6] &&
		!pinInputRead[6]) else $error("pin6 read");
	a_pc_map: assert property (
		pinChangeSrc == pinInputRead) else $error("pc map");
	a_adc_sel: assert property (
		adcChannelSel == $past(adcDiginDisable)) else $error("adc sel");
	a_pin6_in: assert property (
		$past(reset_pin_disable_fuse) |-> padDiginEn[6]) else $error("pin6 in");
	a_digin_off: assert property (
		(padDiginEn[5:0] & $past(adcDiginDisable & ~(pinChangeMask[5:0] &
		{6{pin_change_group1_enable}}))) == 6'h00) else $error("digin");
	a_owner_sel: assert property (
		twiOwner == ($past(two_wire_enable) ? OWNER_TWI_type : OWNER_PORT_type))
		else $error("owner");
	a_ext_rst: assert property (
		$past(reset_pin_disable_fuse) |-> extResetLevel) else $error("rst lvl");
	a_rst_cut: assert property (
		!$past(reset_pin_disable_fuse) |-> !padOutEn[6] && !padOut[6])
		else $error("pin6 drive");
	// A filtered line may only move after the pad held the new level
	a_spike_sda: assert property (
		$changed(sdaIn) |-> $past(padIn[4], 3) == sdaIn &&
		$past(padIn[4], SPIKE_CYCLES + 2) == sdaIn) else $error("sda spike");
	a_spike_scl: assert property (
		$changed(sclIn) |-> $past(padIn[5], 3) == sclIn &&
		$past(padIn[5], SPIKE_CYCLES + 2) == sclIn) else $error("scl spike");
	c_twi: cover property (two_wire_enable && sclDriveLow);
	c_fuse: cover property (reset_pin_disable_fuse);
	c_pc6: cover property (pin_change_group1_enable && pinChangeMask[6]);
endmodule
bind port_c_alt_function_mux port_c_mux_props #(.SPIKE_CYCLES(SPIKE_CYCLES))
	port_c_mux_props_inst (.ref_clk, .nrst, .reset_pin_disable_fuse,
	.two_wire_enable, .pin_change_group1_enable, .portDirReg, .pinChangeMask,
	.adcDiginDisable, .sclDriveLow, .sdaDriveLow, .padOut, .padOutEn,
	.padDiginEn, .pinInputRead, .dirRead, .outRead, .pinChangeSrc,
	.adcChannelSel, .extResetLevel, .twiOwner, .padIn, .sclIn, .sdaIn);

// *** bench/tb_top.sv ***
module tb_top
	import port_c_mux_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 0, nrst = 0, reset_pin_disable_fuse = 0;
	logic two_wire_enable = 0, pin_change_group1_enable = 0;
	logic global_pullup_disable = 0, sclDriveLow = 0, sdaDriveLow = 0;
	logic [7:0] portDirReg = 0, portOutReg = 0, pinChangeMask = 0;
	logic [7:0] extVal = 8'hFF, padIn, padOut, padOutEn, padPullup;
	logic [7:0] padDiginEn, pinInputRead, dirRead, outRead;
	logic [5:0] adcDiginDisable = 0, adcChannelSel;
	logic [15:8] pinChangeSrc;
	logic extResetLevel, sclIn, sdaIn;
	pin_owner_type twiOwner;
	int nErrors, comparisons;
	port_c_alt_function_mux #(.SPIKE_CYCLES(2)) port_c_alt_function_mux_inst (
		.ref_clk, .nrst, .clkEn(1'b1), .reset_pin_disable_fuse,
		.two_wire_enable, .pin_change_group1_enable, .global_pullup_disable,
		.portDirReg, .portOutReg, .pinChangeMask, .adcDiginDisable,
		.sclDriveLow, .sdaDriveLow, .padIn, .padOut, .padOutEn, .padPullup,
		.padDiginEn, .pinInputRead, .dirRead, .outRead, .pinChangeSrc,
		.adcChannelSel, .extResetLevel, .sclIn, .sdaIn, .twiOwner);
	pad_model pad_model_inst (.padOut, .padOutEn, .extVal, .padIn);
	always #12.5 ref_clk = ~ref_clk;
	// Inputs move 2 ns after the edge, never on it
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#2;
	endtask
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			nErrors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic results;
		$display("comparisons %0d nErrors %0d", comparisons, nErrors);
		if (nErrors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Pin 6 pad bits checked apart: reset mode keeps its driver off
	task automatic t_port;
		portDirReg = 8'h4F;
		portOutReg = 8'hF5;
		step(2);
		chk("oe", padOutEn & 8'hBF, 8'h0F);
		chk("out", padOut & 8'hBF, 8'hB5);
		chk("pu", padPullup & 8'hBF, 8'hB0);
		chk("rd6", {dirRead[6], outRead[6]}, 2'h0);
		chk("rd", {dirRead, outRead}, 16'h0FB5);
		chk("pad6", {padOutEn[6], padOut[6]}, 2'h0);
		global_pullup_disable = 1;
		step(2);
		chk("pud", padPullup & 8'hBF, 8'h00);
		$display("t_port done");
	endtask
	task automatic t_twi;
		{portDirReg, portOutReg, global_pullup_disable} = {16'h3030, 1'b0};
		{two_wire_enable, sclDriveLow} = 2'h3;
		step(8);
		chk("own", twiOwner, OWNER_TWI_type);
		chk("oe", padOutEn[5:4], 2'h2);
		chk("out", padOut[5:4], 2'h0);
		chk("pu", padPullup[5:4], 2'h3);
		chk("lines", {sclIn, sdaIn}, 2'h1);
		$display("t_twi done");
	endtask
	// A one-cycle dip on the data line must never get through
	task automatic t_spike;
		logic seenLow;
		seenLow = 0;
		sclDriveLow = 0;
		extVal[4] = 0;
		step(1);
		extVal[4] = 1;
		repeat (8) begin
			step(1);
			seenLow |= (sdaIn !== 1'b1);
		end
		chk("spike", seenLow, 1'b0);
		extVal[4] = 0;
		step(8);
		chk("sda", {sclIn, sdaIn}, 2'h2);
		{extVal[4], two_wire_enable} = 2'h2;
		$display("t_spike done");
	endtask
	task automatic t_input;
		{portDirReg, extVal, adcDiginDisable} = {16'h00E5, 6'h3C};
		{pinChangeMask, pin_change_group1_enable} = {8'h4F, 1'b1};
		step(5);
		chk("die", padDiginEn, 8'h8F);
		chk("in", pinInputRead, 8'h85);
		chk("pc", pinChangeSrc, 8'h85);
		chk("adc", adcChannelSel, 6'h3C);
		chk("rst", extResetLevel, 1'b1);
		extVal[6] = 0;
		step(5);
		chk("rst", {extResetLevel, pinInputRead[6]}, 2'h0);
		{reset_pin_disable_fuse, extVal[6], portOutReg[6]} = 3'h7;
		step(5);
		chk("fuse", {padDiginEn[6], pinInputRead[6]}, 2'h3);
		chk("rst", extResetLevel, 1'b1);
		chk("fuse6", {outRead[6], padPullup[6], padOutEn[6]}, 3'h6);
		$display("t_input done");
	endtask
	initial begin
		step(3);
		nrst = 1;
		t_port();
		t_twi();
		t_spike();
		t_input();
		results();
	end
	// Whole run is well under 200 cycles
	initial begin
		#125000;
		nErrors++;
		results();
	end
endmodule
